/* File: design/irq_hold_ctrl.sv */
// Purpose: Interrupt pending/mask logic, acknowledge and bus-hold grant
// Assumes: One clock, pins synchronised here, AHB-Lite register slave
// Notes: Core handshake is vecTake pulse in, irqReq/vecAddr/irqAckOut_n out
`include "irq_hold_defines.svh"

module irq_hold_ctrl
   import irq_hold_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // External pins
   input wire logic sharedParkIrqPin_n,
   input wire logic extIrqLineB_n,
   input wire logic extIrqLineC_n,
   input wire logic nmiPin_n,
   // On-chip peripherals, level requests
   input wire logic [13:0] periphIrq,
   // Core side
   input wire logic vecTake,
   input wire logic sleepExit,
   output logic irqReq,
   output logic [15:0] vecAddr,
   output logic irqAckOut_n,
   output logic busParkGrant_n,
   output logic busDriveEn
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] pinMeta_r, pinSync_r, pinPrev_r;
   logic [3:0] pinMeta_nxt, pinSync_nxt, pinPrev_nxt;

   always_comb begin
      pinMeta_nxt = {nmiPin_n, extIrqLineC_n, extIrqLineB_n, sharedParkIrqPin_n};
      pinSync_nxt = pinMeta_r;
      pinPrev_nxt = pinSync_r;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pinMeta_r <= 4'hf;
         pinSync_r <= 4'hf;
         pinPrev_r <= 4'hf;
      end else begin
         pinMeta_r <= pinMeta_nxt;
         pinSync_r <= pinSync_nxt;
         pinPrev_r <= pinPrev_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   logic wrPend_r, wrPend_nxt;
   logic [11:0] wrAddr_r, wrAddr_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic [15:0] pending_r, pending_nxt;
   logic [15:0] mask_r, mask_nxt;
   logic [15:0] status0_r, status0_nxt;
   logic [15:0] extCtl_r, extCtl_nxt;
   logic sleep_r, sleep_nxt;
   logic [15:0] swIrq;
   logic swNmi;
   logic seqBusy;
   logic addrPhase;

   assign addrPhase = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   always_comb begin
      wrPend_nxt = addrPhase && hwrite;
      wrAddr_nxt = addrPhase ? haddr : wrAddr_r;
      hrdata_nxt = hrdata_r;
      if (addrPhase && !hwrite) begin
         unique case (haddr)
            `OFS_PENDING: hrdata_nxt = {16'h0000, pending_r};
            `OFS_MASK: hrdata_nxt = {16'h0000, mask_r};
            `OFS_STATUS0: hrdata_nxt = {16'h0000, status0_r};
            `OFS_EXTCTL: hrdata_nxt = {16'h0000, extCtl_r};
            `OFS_CORE: hrdata_nxt = {30'h0, seqBusy, sleep_r};
            default: hrdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 12'h000;
         hrdata_r <= 32'h0000_0000;
      end else begin
         wrPend_r <= wrPend_nxt;
         wrAddr_r <= wrAddr_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   logic wrPending, wrMask, wrSt0, wrExt, wrCore, wrSw;
   assign wrPending = wrPend_r && (wrAddr_r == `OFS_PENDING);
   assign wrMask = wrPend_r && (wrAddr_r == `OFS_MASK);
   assign wrSt0 = wrPend_r && (wrAddr_r == `OFS_STATUS0);
   assign wrExt = wrPend_r && (wrAddr_r == `OFS_EXTCTL);
   assign wrCore = wrPend_r && (wrAddr_r == `OFS_CORE);
   assign wrSw = wrPend_r && (wrAddr_r == `OFS_SWIRQ);
   assign swIrq = wrSw ? hwdata[15:0] : 16'h0000;
   assign swNmi = wrCore && hwdata[`CORE_NMI_BIT];

   // ----------------------------------------------------------------
   // Edge detection and event capture
   // ----------------------------------------------------------------
   logic fallA, riseA, evA, fallB, fallC, fallNmi;
   logic parkMode, gEnable;
   logic [15:0] events, enabled;

   always_comb begin
      parkMode = extCtl_r[`EXT_PARK_SEL_BIT];
      fallA = pinPrev_r[0] && !pinSync_r[0];
      riseA = !pinPrev_r[0] && pinSync_r[0];
      evA = fallA || (extCtl_r[`EXT_MODE_BIT] && riseA);
      fallB = pinPrev_r[1] && !pinSync_r[1];
      fallC = pinPrev_r[2] && !pinSync_r[2];
      fallNmi = pinPrev_r[3] && !pinSync_r[3];
      events = swIrq;
      events[`SRC_LINE_A] = swIrq[`SRC_LINE_A] || evA;
      // Edge, not flag level: a standing flag would re-pend after each take
      events[`SRC_LINE_BC] = swIrq[`SRC_LINE_BC]
         || (fallB && !extCtl_r[`EXT_B_MASK_BIT])
         || (fallC && !extCtl_r[`EXT_C_MASK_BIT]);
      events[15:`SRC_PERIPH_LO] = swIrq[15:`SRC_PERIPH_LO] | periphIrq;
      gEnable = !status0_r[`ST0_GDIS_BIT];
      enabled = pending_r & mask_r & {16{gEnable}};
   end

   // ----------------------------------------------------------------
   // Priority and vector sequence
   // ----------------------------------------------------------------
   seq_state_t state_r, state_nxt;
   logic nmiPend_r, nmiPend_nxt;
   logic [4:0] winner;
   logic [4:0] presIdx_r, presIdx_nxt;
   logic [15:0] vecAddr_nxt;
   logic irqReq_nxt, ack_nxt, grant_nxt, drive_nxt;
   logic irqReq_r, ack_r, grant_r, drive_r;
   logic [15:0] vecAddr_r;
   logic [15:0] takeClr;

   assign seqBusy = (state_r != ACK_IDLE);

   always_comb begin
      winner = 5'd16;
      for (int i = 15; i >= 0; i--) begin
         if (enabled[i]) begin
            winner = 5'(i);
         end
      end
   end

   always_comb begin
      state_nxt = state_r;
      nmiPend_nxt = nmiPend_r || fallNmi || swNmi;
      takeClr = 16'h0000;
      irqReq_nxt = 1'b0;
      ack_nxt = 1'b1;
      vecAddr_nxt = vecAddr_r;
      presIdx_nxt = presIdx_r;
      grant_nxt = grant_r;
      drive_nxt = drive_r;
      sleep_nxt = sleep_r;
      if (wrCore && hwdata[`CORE_SLEEP_BIT]) begin
         sleep_nxt = 1'b1;
      end
      unique case (state_r)
         ACK_IDLE: begin
            if (nmiPend_r) begin
               irqReq_nxt = 1'b1;
               vecAddr_nxt = 16'h0000;
               presIdx_nxt = 5'd16;
            end else if (winner != 5'd16) begin
               irqReq_nxt = 1'b1;
               vecAddr_nxt = `VEC_BASE + {10'h000, winner, 1'b0};
               presIdx_nxt = winner;
            end
            // Take what was presented, not what won this cycle
            if (irqReq_r && vecTake) begin
               state_nxt = ACK_FETCH;
               ack_nxt = 1'b0;
               irqReq_nxt = 1'b0;
               vecAddr_nxt = vecAddr_r;
               presIdx_nxt = presIdx_r;
               if (presIdx_r == 5'd16) begin
                  nmiPend_nxt = fallNmi || swNmi;
               end else begin
                  takeClr[presIdx_r[3:0]] = 1'b1;
               end
            end
         end
         ACK_FETCH: begin
            // Hold route needs the line-A routine to reach sleep
            if (parkMode && presIdx_r == 5'(`SRC_LINE_A)) begin
               state_nxt = PARK_WAIT;
            end else begin
               state_nxt = ACK_IDLE;
            end
         end
         PARK_WAIT: begin
            if (sleep_r && !pinSync_r[0]) begin
               grant_nxt = 1'b0;
               drive_nxt = 1'b0;
               state_nxt = PARK_HELD;
            end else if (pinSync_r[0] || sleepExit) begin
               state_nxt = ACK_IDLE;
            end
         end
         PARK_HELD: begin
            // Master owns the bus until it releases the pin, NMI arrives or the core exits sleep
            if (pinSync_r[0] || nmiPend_r || sleepExit) begin
               grant_nxt = 1'b1;
               drive_nxt = 1'b1;
               sleep_nxt = 1'b0;
               state_nxt = ACK_IDLE;
            end
         end
      endcase
      if (sleepExit) begin
         sleep_nxt = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register file next values
   // ----------------------------------------------------------------
   always_comb begin
      pending_nxt = pending_r & ~takeClr;
      if (wrPending) begin
         pending_nxt = pending_nxt & ~hwdata[15:0];
      end
      pending_nxt = pending_nxt | events; // set wins over clear
      mask_nxt = wrMask ? hwdata[15:0] : mask_r;
      status0_nxt = wrSt0 ? hwdata[15:0] : status0_r;
      extCtl_nxt = extCtl_r;
      if (wrExt) begin
         extCtl_nxt = hwdata[15:0] & ~16'h0060;
         extCtl_nxt[`EXT_B_FLAG_BIT] = extCtl_r[`EXT_B_FLAG_BIT] & ~hwdata[`EXT_B_FLAG_BIT];
         extCtl_nxt[`EXT_C_FLAG_BIT] = extCtl_r[`EXT_C_FLAG_BIT] & ~hwdata[`EXT_C_FLAG_BIT];
      end
      if (fallB) begin
         extCtl_nxt[`EXT_B_FLAG_BIT] = 1'b1;
      end
      if (fallC) begin
         extCtl_nxt[`EXT_C_FLAG_BIT] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pending_r <= `RST_PENDING;
         mask_r <= `RST_MASK;
         status0_r <= `RST_STATUS0;
         extCtl_r <= `RST_EXTCTL;
         sleep_r <= 1'b0;
         state_r <= ACK_IDLE;
         nmiPend_r <= 1'b0;
         irqReq_r <= 1'b0;
         ack_r <= 1'b1;
         vecAddr_r <= 16'h0000;
         presIdx_r <= 5'd0;
         grant_r <= 1'b1;
         drive_r <= 1'b1;
      end else begin
         pending_r <= pending_nxt;
         mask_r <= mask_nxt;
         status0_r <= status0_nxt;
         extCtl_r <= extCtl_nxt;
         sleep_r <= sleep_nxt;
         state_r <= state_nxt;
         nmiPend_r <= nmiPend_nxt;
         irqReq_r <= irqReq_nxt;
         ack_r <= ack_nxt;
         vecAddr_r <= vecAddr_nxt;
         presIdx_r <= presIdx_nxt;
         grant_r <= grant_nxt;
         drive_r <= drive_nxt;
      end
   end

   assign irqReq = irqReq_r;
   assign irqAckOut_n = ack_r;
   assign vecAddr = vecAddr_r;
   assign busParkGrant_n = grant_r;
   assign busDriveEn = drive_r;

endmodule : irq_hold_ctrl

/* File: pkg/irq_hold_defines.svh */
// Purpose: Offsets, field positions, reset values for the interrupt and bus-hold block
// Assumes: AHB-Lite word registers, 16 data bits in the low half
// Notes: Definitions only
`ifndef IRQ_HOLD_DEFINES_SVH
`define IRQ_HOLD_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_PENDING 12'h000
`define OFS_MASK 12'h004
`define OFS_STATUS0 12'h008
`define OFS_EXTCTL 12'h00c
`define OFS_CORE 12'h010
`define OFS_SWIRQ 12'h014

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ST0_GDIS_BIT 9
`define EXT_MODE_BIT 4
`define EXT_PARK_SEL_BIT 0
`define EXT_B_MASK_BIT 1
`define EXT_C_MASK_BIT 2
`define EXT_B_FLAG_BIT 5
`define EXT_C_FLAG_BIT 6
`define CORE_SLEEP_BIT 0
`define CORE_NMI_BIT 1
`define SRC_LINE_A 0
`define SRC_LINE_BC 1
`define SRC_PERIPH_LO 2

// ----------------------------------------------------------------
// Reset values and vector base
// ----------------------------------------------------------------
`define RST_PENDING 16'h0000
`define RST_MASK 16'h0000
`define RST_STATUS0 16'h0200
`define RST_EXTCTL 16'h0000
`define VEC_BASE 16'h0002

`endif

/* File: pkg/irq_hold_pkg.sv */
// Purpose: Types for the interrupt and bus-hold block
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in the defines header
package irq_hold_pkg;

   typedef enum logic [1:0] {
      ACK_IDLE = 2'b00,
      ACK_FETCH = 2'b01,
      PARK_WAIT = 2'b10,
      PARK_HELD = 2'b11
   } seq_state_t;

endpackage : irq_hold_pkg

/* File: verif/irq_hold_ctrl_properties.sv */
// Purpose: Port-level properties of the interrupt and bus-hold block
// Assumes: One clock domain, reset rstn
// Notes: Attached by bind below
module irq_hold_ctrl_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Observed ports
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic vecTake,
   input wire logic irqReq,
   input wire logic [15:0] vecAddr,
   input wire logic irqAckOut_n,
   input wire logic sharedParkIrqPin_n,
   input wire logic busParkGrant_n,
   input wire logic busDriveEn
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus not ready or not okay");
   property p_ack_take; vecTake && irqReq |=> !irqAckOut_n; endproperty
   a_ack_take: assert property (p_ack_take) else $error("no acknowledge after take");
   property p_ack_pulse; !irqAckOut_n |=> irqAckOut_n; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge too long");
   property p_ack_cause; $fell(irqAckOut_n) |-> $past(vecTake) && $past(irqReq); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without take");
   property p_refused; vecTake && !irqReq |=> irqAckOut_n; endproperty
   a_refused: assert property (p_refused) else $error("take without request acked");
   property p_bus_free; busDriveEn == busParkGrant_n; endproperty
   a_bus_free: assert property (p_bus_free) else $error("bus drive and grant disagree");
   property p_release; sharedParkIrqPin_n [*5] |=> busParkGrant_n; endproperty
   a_release: assert property (p_release) else $error("grant kept after pin high");
   property p_vec; irqReq |-> vecAddr <= 16'h0020 && !vecAddr[0]; endproperty
   a_vec: assert property (p_vec) else $error("vector outside table");
endmodule : irq_hold_ctrl_properties

bind irq_hold_ctrl irq_hold_ctrl_properties irq_hold_ctrl_properties_i (
   .core_clk(core_clk), .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp),
   .vecTake(vecTake), .irqReq(irqReq), .vecAddr(vecAddr), .irqAckOut_n(irqAckOut_n),
   .sharedParkIrqPin_n(sharedParkIrqPin_n), .busParkGrant_n(busParkGrant_n),
   .busDriveEn(busDriveEn));

/* File: verif/core_model.sv */
// Purpose: Core that takes presented requests and records the vector
// Assumes: vecTake pulse accepted while irqReq high
// Notes: LAT sets the pause after each take, so prompt or slow
module core_model #(
   parameter int LAT = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Block side
   input wire logic irqReq,
   input wire logic [15:0] vecAddr,
   input wire logic wake,
   output logic vecTake,
   output logic sleepExit,
   output logic [15:0] takenVec
);
   logic [2:0] gap_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sleepExit <= 1'b0;
         vecTake <= 1'b0;
         gap_r <= 3'h0;
         takenVec <= 16'h0000;
      end else begin
         sleepExit <= wake;
         vecTake <= 1'b0;
         // Pause keeps clear of the cycle after ack
         if (vecTake) begin
            takenVec <= vecAddr;
            gap_r <= 3'(LAT);
         end else if (gap_r != 3'h0) begin
            gap_r <= gap_r - 3'h1;
         end else if (irqReq) begin
            vecTake <= 1'b1;
         end
      end
   end
endmodule : core_model

/* File: verif/cpu_interrupt_and_bus_hold_logic_tb.sv */
// Purpose: Self-checking bench of the interrupt and bus-hold block
// Assumes: Zero-wait AHB-Lite slave, core model takes every request
// Notes: Vectors noted in a queue, checked when the ack appears
`include "irq_hold_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module cpu_interrupt_and_bus_hold_logic_tb;
   import irq_hold_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rstn, hsel, hwrite, hready, hreadyout, hresp, vecTake, sleepExit;
   logic irqReq, irqAckOut_n, busParkGrant_n, busDriveEn, pinA, pinB, pinC, nmi, wake;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rv;
   logic [13:0] periphIrq;
   logic [15:0] vecAddr, takenVec, e;
   logic [15:0] expq[$];
   int mismatches, total_checks, cycles;
   assign hready = hreadyout;
   irq_hold_ctrl irq_hold_ctrl_i (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sharedParkIrqPin_n(pinA), .extIrqLineB_n(pinB), .extIrqLineC_n(pinC),
      .nmiPin_n(nmi), .periphIrq(periphIrq), .vecTake(vecTake), .sleepExit(sleepExit),
      .irqReq(irqReq), .vecAddr(vecAddr), .irqAckOut_n(irqAckOut_n),
      .busParkGrant_n(busParkGrant_n), .busDriveEn(busDriveEn));
   core_model #(.LAT(4)) core_model_i (.core_clk(core_clk), .rstn(rstn), .irqReq(irqReq),
      .vecAddr(vecAddr), .wake(wake), .vecTake(vecTake), .sleepExit(sleepExit),
      .takenVec(takenVec));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      `CHK("reg", x, r)
   endtask : rd
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         tally_and_finish();
      end
      if (irqAckOut_n === 1'b0) begin
         e = (expq.size() != 0) ? expq.pop_front() : 16'hxxxx;
         `CHK("vector", e, takenVec)
      end
   end
   initial begin
      {rstn, hsel, wake, htrans, haddr, hwrite, hwdata, periphIrq} = '0;
      {pinA, pinB, pinC, nmi} = 4'hf;
      hsize = 3'b010;
      tick(2);
      rstn <= 1'b1;
      rd(`OFS_PENDING, `RST_PENDING);
      rd(`OFS_MASK, `RST_MASK);
      rd(`OFS_STATUS0, `RST_STATUS0);
      rd(`OFS_EXTCTL, `RST_EXTCTL);
      rd(12'h020, 32'h0);
      wr(`OFS_STATUS0, 32'h0);
      rv = {16'h0, lfsr(lfsr(16'h0001))};
      @(posedge core_clk) periphIrq <= rv[13:0];
      @(posedge core_clk) periphIrq <= 14'h0;
      tick(2);
      rd(`OFS_PENDING, {rv[13:0], 2'b00});
      wr(`OFS_PENDING, 32'hffff);
      rd(`OFS_PENDING, 32'h0);
      wr(`OFS_STATUS0, 32'h200);
      wr(`OFS_MASK, 32'hffff);
      @(posedge core_clk) periphIrq <= 14'h0088;
      @(posedge core_clk) periphIrq <= 14'h0;
      expq.push_back(16'h0000);
      nmi <= 1'b0;
      tick(15);
      `CHK("queue", 0, expq.size())
      nmi <= 1'b1;
      expq.push_back(16'h000c);
      expq.push_back(16'h0014);
      wr(`OFS_STATUS0, 32'h0);
      tick(20);
      `CHK("queue", 0, expq.size())
      wr(`OFS_EXTCTL, 32'h4);
      expq.push_back(16'h0004);
      pinC <= 1'b0;
      tick(10);
      pinB <= 1'b0;
      tick(15);
      pinB <= 1'b1;
      pinC <= 1'b1;
      `CHK("queue", 0, expq.size())
      rd(`OFS_EXTCTL, 32'h64);
      wr(`OFS_EXTCTL, 32'h70);
      rd(`OFS_EXTCTL, 32'h10);
      expq.push_back(16'h0002);
      pinA <= 1'b0;
      tick(15);
      expq.push_back(16'h0002);
      pinA <= 1'b1;
      tick(15);
      `CHK("queue", 0, expq.size())
      wr(`OFS_EXTCTL, 32'h1);
      expq.push_back(16'h0002);
      pinA <= 1'b0;
      tick(15);
      wr(`OFS_CORE, 32'h1);
      for (int i = 0; i < 40 && busParkGrant_n !== 1'b0; i++) @(posedge core_clk);
      `CHK("grant", 1'b0, busParkGrant_n)
      `CHK("drive", 1'b0, busDriveEn)
      pinA <= 1'b1;
      for (int i = 0; i < 40 && busParkGrant_n !== 1'b1; i++) @(posedge core_clk);
      `CHK("drive", 1'b1, busDriveEn)
      expq.push_back(16'h0002);
      pinA <= 1'b0;
      tick(15);
      wr(`OFS_CORE, 32'h1);
      for (int i = 0; i < 40 && busParkGrant_n !== 1'b0; i++) @(posedge core_clk);
      rd(`OFS_CORE, 32'h3);
      wake <= 1'b1;
      @(posedge core_clk) wake <= 1'b0;
      for (int i = 0; i < 40 && busParkGrant_n !== 1'b1; i++) @(posedge core_clk);
      `CHK("grant", 1'b1, busParkGrant_n)
      rd(`OFS_CORE, 32'h0);
      pinA <= 1'b1;
      expq.push_back(16'h0000);
      expq.push_back(16'h0020);
      wr(`OFS_CORE, 32'h2);
      wr(`OFS_SWIRQ, 32'h8000);
      tick(20);
      `CHK("queue", 0, expq.size())
      tally_and_finish();
   end
endmodule : cpu_interrupt_and_bus_hold_logic_tb
